// >>> gpio_led_pin_config.sv
`include "gpio_led_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module gpio_led_pin_config #(
  parameter int NPINS = 3
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone classic slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  output logic                       err_o,
  // General pins, three-signal form
  input  wire logic [NPINS-1:0]      pin_i,
  output logic      [NPINS-1:0]      pin_o,
  output logic      [NPINS-1:0]      pin_oe_o,
  // LED drive from the link status logic
  input  wire logic [NPINS-1:0]      led_src_i,
  // Interrupt enables and status
  input  wire logic [NPINS-1:0]      pin_irq_enable_i,
  output logic      [NPINS-1:0]      pin_irq_status_o,
  output logic                       pin_irq_o,
  // Serial memory engine side
  input  wire logic                  rom_clk_src_i,
  input  wire logic                  rom_dat_src_i,
  input  wire logic                  rom_dat_oe_src_i,
  output logic                       rom_dat_in_o,
  input  wire gpio_led_pkg::mii_dbg_t mii_dbg_i,
  // Shared pins
  input  wire logic                  rom_data_pin_i,
  output logic                       rom_data_pin_o,
  output logic                       rom_data_pin_oe_o,
  output logic                       rom_clock_pin_o,
  output logic                       rom_clock_pin_oe_o
);

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  logic [31:0]            cfg_reg;
  logic [31:0]            cfg_next;
  logic                   ack_reg;
  logic                   ack_next;
  logic                   err_reg;
  logic                   err_next;
  logic [31:0]            rdat_reg;
  logic [31:0]            rdat_next;
  logic [NPINS-1:0]       samp_reg;
  logic [31:0]            bmask;
  logic                   req;
  logic                   hit;

  assign req = cyc_i && stb_i && !ack_reg && !err_reg;
  assign hit = (adr_i == `PIN_CFG_OFFSET);

  // Byte lanes expanded to bit mask
  always_comb
  begin
    bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  end

  // Bus decode; answer one cycle after the request
  // The answer is registered, so a request is taken only while no
  // answer stands; this keeps a held strobe from writing twice.
  // Unmapped addresses get err instead of ack, so software
  // sees a refused access rather than silent zero data.
  always_comb
  begin
    cfg_next  = cfg_reg;
    ack_next  = 1'b0;
    err_next  = 1'b0;
    rdat_next = rdat_reg;
    if (req)
    begin
      if (hit)
      begin
        ack_next = 1'b1;
        if (we_i)
        begin
          cfg_next = (cfg_reg & ~(bmask & `PIN_CFG_WMASK))
                   | (dat_i & bmask & `PIN_CFG_WMASK);
        end
        else
        begin
          rdat_next = {cfg_reg[31:NPINS], samp_reg};
        end
      end
      else
      begin
        err_next  = 1'b1;
        rdat_next = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_reg  <= `PIN_CFG_RESET;
      ack_reg  <= 1'b0;
      err_reg  <= 1'b0;
      rdat_reg <= 32'h00000000;
      samp_reg <= '0;
    end
    else
    begin
      cfg_reg  <= cfg_next;
      ack_reg  <= ack_next;
      err_reg  <= err_next;
      rdat_reg <= rdat_next;
      samp_reg <= pin_i;
    end
  end

  assign ack_o = ack_reg;
  assign err_o = err_reg;
  assign dat_o = rdat_reg;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  // Named slices of the one register; all fields reset to zero,
  // which leaves every pin an input and the rom pins in rom use.
  // General pins come up undriven, so they do not fight the board at power-up; the rom clock pin is always driven.
  logic [NPINS-1:0]    led_select_bits;
  logic [NPINS-1:0]    pin_irq_level_sel;
  logic [NPINS-1:0]    pin_driver_type;
  logic [NPINS-1:0]    pin_direction;
  logic [NPINS-1:0]    pin_value;
  logic [1:0]          extra_output_value;
  gpio_led_pkg::rom_fn_t rom_pin_function_sel;

  assign led_select_bits    = cfg_reg[`F_LED_SEL_LO +: NPINS];
  assign pin_irq_level_sel  = cfg_reg[`F_IRQ_LEVEL_LO +: NPINS];
  assign pin_driver_type    = cfg_reg[`F_DRV_LO +: NPINS];
  assign pin_direction      = cfg_reg[`F_DIR_LO +: NPINS];
  assign pin_value          = cfg_reg[`F_PIN_VALUE_LO +: NPINS];
  assign extra_output_value = cfg_reg[`F_EXTRA_OUT_LO +: 2];
  assign rom_pin_function_sel = gpio_led_pkg::rom_fn_t'(cfg_reg[`F_ROM_FN_LO +: 3]);

  // ----------------------------------------
  // Pin drivers and interrupt detection
  // ----------------------------------------
  gpio_led_pkg::pin_drive_t drv_next;
  gpio_led_pkg::pin_drive_t drv_reg;
  logic [NPINS-1:0]         act_level;
  logic [NPINS-1:0]         act_held;
  logic [NPINS-1:0]         irq_sts_reg;
  logic [NPINS-1:0]         irq_sts_next;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      // Drive choice per pin
      always_comb
      begin
        drv_next.out[g] = 1'b0;
        drv_next.oe[g]  = 1'b0;
        if (led_select_bits[g])
        begin
          drv_next.out[g] = led_src_i[g];
          drv_next.oe[g]  = 1'b1;
        end
        else if (pin_direction[g])
        begin
          drv_next.out[g] = pin_value[g];
          drv_next.oe[g]  = pin_driver_type[g] | ~pin_value[g];
        end
      end

      assign act_level[g] = ~(samp_reg[g] ^ pin_irq_level_sel[g]) & ~led_select_bits[g];

      // short pulses filtered
      // The filter sees the synchronised level, so one clock of
      // activity never counts; two samples are needed. At the
      // 100 ns clock this is always longer than the minimum width.
      level_filter #(
        .CYCLES (`IRQ_FILTER_CYCLES)
      ) u_filt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (act_level[g]),
        .level_o (act_held[g])
      );
    end
  endgenerate

  // Level-sensitive status follows the held level
  // No sticky bit here: clearing belongs to the outside status
  // register, which latches this level under its own rules.
  always_comb
  begin
    irq_sts_next = act_held;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      drv_reg     <= '0;
      irq_sts_reg <= '0;
    end
    else
    begin
      drv_reg     <= drv_next;
      irq_sts_reg <= irq_sts_next;
    end
  end

  assign pin_o            = drv_reg.out;
  assign pin_oe_o         = drv_reg.oe;
  assign pin_irq_status_o = irq_sts_reg;
  assign pin_irq_o        = |(irq_sts_reg & pin_irq_enable_i);

  // ----------------------------------------
  // Shared serial-memory pins
  // ----------------------------------------
  logic dpin_out;
  logic dpin_oe;
  logic cpin_out;
  logic cpin_oe;

  // Mux is combinational; reserved codes fall back to rom use
  // Combinational so the debug clocks pass without a cycle of lag.
  // Switching codes mid rom cycle can glitch both pins; the host
  // must keep the selection steady while the rom engine is busy.
  // The clock pin is always driven; only the data pin turns around.
  always_comb
  begin
    dpin_out = rom_dat_src_i;
    dpin_oe  = rom_dat_oe_src_i;
    cpin_out = rom_clk_src_i;
    cpin_oe  = 1'b1;
    case (rom_pin_function_sel)
      gpio_led_pkg::ROM_FN_ROM:
      begin
        dpin_out = rom_dat_src_i;
      end
      gpio_led_pkg::ROM_FN_EXTRA:
      begin
        dpin_out = extra_output_value[0];
        dpin_oe  = 1'b1;
        cpin_out = extra_output_value[1];
      end
      gpio_led_pkg::ROM_FN_EX3_RXDV:
      begin
        dpin_out = extra_output_value[0];
        dpin_oe  = 1'b1;
        cpin_out = mii_dbg_i.rx_dv;
      end
      gpio_led_pkg::ROM_FN_TXEN_EX4:
      begin
        dpin_out = mii_dbg_i.tx_en;
        dpin_oe  = 1'b1;
        cpin_out = extra_output_value[1];
      end
      gpio_led_pkg::ROM_FN_TXEN_RX:
      begin
        dpin_out = mii_dbg_i.tx_en;
        dpin_oe  = 1'b1;
        cpin_out = mii_dbg_i.rx_dv;
      end
      gpio_led_pkg::ROM_FN_CLOCKS:
      begin
        dpin_out = mii_dbg_i.tx_clk;
        dpin_oe  = 1'b1;
        cpin_out = mii_dbg_i.rx_clk;
      end
      default:
      begin
        dpin_out = rom_dat_src_i;
      end
    endcase
  end

  assign rom_data_pin_o     = dpin_out;
  assign rom_data_pin_oe_o  = dpin_oe;
  assign rom_clock_pin_o    = cpin_out;
  assign rom_clock_pin_oe_o = cpin_oe;
  assign rom_dat_in_o       = rom_data_pin_i;

endmodule

`default_nettype wire

// >>> gpio_led_consts.svh
`ifndef GPIO_LED_CONSTS_SVH
`define GPIO_LED_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PIN_CFG_OFFSET     8'h88
`define PIN_CFG_WMASK      32'h7777071F
`define PIN_CFG_RESET      32'h00000000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_PIN_VALUE_LO     0
`define F_EXTRA_OUT_LO     3
`define F_DIR_LO           8
`define F_DRV_LO           16
`define F_ROM_FN_LO        20
`define F_IRQ_LEVEL_LO     24
`define F_LED_SEL_LO       28

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS      100
`define IRQ_MIN_ACTIVE_NS  40
// Longer than 40 ns: cycles strictly above the figure, at least one
`define IRQ_FILTER_CYCLES  ((`IRQ_MIN_ACTIVE_NS / `CLK_PERIOD_NS) + 1)

`endif

// >>> gpio_led_pkg.sv
package gpio_led_pkg;

  // Pin function choices for the two shared serial-memory pins
  typedef enum logic [2:0] {
    ROM_FN_ROM      = 3'h0,
    ROM_FN_EXTRA    = 3'h1,
    ROM_FN_RSVD2    = 3'h2,
    ROM_FN_EX3_RXDV = 3'h3,
    ROM_FN_RSVD4    = 3'h4,
    ROM_FN_TXEN_EX4 = 3'h5,
    ROM_FN_TXEN_RX  = 3'h6,
    ROM_FN_CLOCKS   = 3'h7
  } rom_fn_t;

  // Per-pin driver pair
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } pin_drive_t;

  // Debug signals that may be routed to shared pins
  typedef struct packed {
    logic tx_en;
    logic rx_dv;
    logic tx_clk;
    logic rx_clk;
  } mii_dbg_t;

endpackage

// >>> level_filter.sv
`timescale 1ns/1ps
`default_nettype none

// Passes a level only after it has held for CYCLES+1 clocks
module level_filter #(
  parameter int CYCLES = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      level_o
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       out_reg;
  logic       out_next;

  // ----------------------------------------
  // Hold counter
  // ----------------------------------------
  always_comb
  begin
    cnt_next = cnt_reg;
    out_next = 1'b0;
    if (!level_i)
    begin
      cnt_next = 8'h00;
    end
    else if (cnt_reg < 8'(CYCLES))
    begin
      cnt_next = cnt_reg + 8'h01;
    end
    else
    begin
      out_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= 8'h00;
      out_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign level_o = out_reg;

endmodule

`default_nettype wire

// >>> gpio_led_pin_config_properties.sv
`include "gpio_led_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module gpio_led_pin_config_checker #(
  parameter int NPINS = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [7:0]       adr_i,
  input  wire logic             ack_o,
  input  wire logic             err_o,
  input  wire logic [NPINS-1:0] pin_oe_o,
  input  wire logic [NPINS-1:0] pin_irq_enable_i,
  input  wire logic [NPINS-1:0] pin_irq_status_o,
  input  wire logic             pin_irq_o
);
  logic wrote_reg;
  logic wrote_next;
  logic req;

  // First write ends the all-input period after reset
  always_comb wrote_next = wrote_reg | (ack_o & we_i);
  always_ff @(posedge clk_i) wrote_reg <= rst_i ? 1'b0 : wrote_next;
  assign req = cyc_i & stb_i & ~ack_o & ~err_o;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_on_hit_a:
  assert property (req && adr_i == `PIN_CFG_OFFSET |=> ack_o && !err_o)
    else $error("mapped access not acked");
  err_on_miss_a:
  assert property (req && adr_i != `PIN_CFG_OFFSET |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  answer_pulse_a:
  assert property (ack_o || err_o |=> !ack_o && !err_o)
    else $error("answer longer than one cycle");
  answer_cause_a:
  assert property (ack_o || err_o |-> $past(cyc_i && stb_i))
    else $error("answer without request");
  idle_quiet_a:
  assert property (!cyc_i ##1 !cyc_i |-> !ack_o && !err_o)
    else $error("answer while idle");
  reset_state_a:
  assert property (disable iff (1'b0) rst_i |=> pin_oe_o == '0 && pin_irq_status_o == '0)
    else $error("pins or status active after reset");
  irq_gate_a:
  assert property (pin_irq_o == |(pin_irq_status_o & pin_irq_enable_i))
    else $error("host irq not status and enable");
  input_default_a:
  assert property (!wrote_reg |-> pin_oe_o == '0)
    else $error("pin driven before any write");
endmodule

bind gpio_led_pin_config gpio_led_pin_config_checker #(.NPINS(NPINS)) i_checker (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .ack_o, .err_o,
  .pin_oe_o, .pin_irq_enable_i, .pin_irq_status_o, .pin_irq_o
);
`default_nettype wire

// >>> pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

// Board side: pull-ups on general pins and the serial data line
module pin_partner (
  input  wire logic [2:0] drv_i,
  input  wire logic [2:0] oe_i,
  input  wire logic [2:0] ext_en_i,
  input  wire logic [2:0] ext_val_i,
  output logic      [2:0] level_o,
  input  wire logic       rom_drv_i,
  input  wire logic       rom_oe_i,
  output logic            rom_level_o
);
  // Released lines float high, which open-drain drive depends on
  always_comb
  begin
    for (int k = 0; k < 3; k++)
      level_o[k] = oe_i[k] ? drv_i[k] : (ext_en_i[k] ? ext_val_i[k] : 1'b1);
    rom_level_o = rom_oe_i ? rom_drv_i : 1'b1;
  end
endmodule
`default_nettype wire

// >>> gpio_led_pin_config_bench.sv
`include "gpio_led_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module gpio_led_pin_config_bench;
  logic                  clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, pin_irq_o;
  logic                  rom_clk_src_i, rom_dat_src_i, rom_dat_oe_src_i, rom_dat_in_o;
  logic                  rom_data_pin_i, rom_data_pin_o, rom_data_pin_oe_o;
  logic                  rom_clock_pin_o, rom_clock_pin_oe_o;
  logic [7:0]            adr_i;
  logic [31:0]           dat_i, dat_o;
  logic [2:0]            pin_i, pin_o, pin_oe_o, led_src_i, pin_irq_enable_i;
  logic [2:0]            pin_irq_status_o, ext_en, ext_val;
  gpio_led_pkg::mii_dbg_t mii_dbg_i;
  int                    n_mismatch, n_checks, t;
  logic [2:0]            fn_tab [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  int                    dsel [6] = '{1, 2, 2, 3, 3, 4};
  int                    csel [6] = '{1, 2, 3, 2, 3, 4};
  localparam logic [7:0] OFS = `PIN_CFG_OFFSET;

  gpio_led_pin_config i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .err_o, .pin_i, .pin_o, .pin_oe_o,
    .led_src_i, .pin_irq_enable_i, .pin_irq_status_o, .pin_irq_o, .rom_clk_src_i,
    .rom_dat_src_i, .rom_dat_oe_src_i, .rom_dat_in_o, .mii_dbg_i, .rom_data_pin_i,
    .rom_data_pin_o, .rom_data_pin_oe_o, .rom_clock_pin_o, .rom_clock_pin_oe_o);
  pin_partner i_board (.drv_i(pin_o), .oe_i(pin_oe_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(pin_i), .rom_drv_i(rom_data_pin_o),
    .rom_oe_i(rom_data_pin_oe_o), .rom_level_o(rom_data_pin_i));

  // Free-running system clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  // Classic cycle; request held until the edge that sees the answer
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    q = dat_o;
    e = err_o;
    if (n >= 20)
    begin
      chk(32'h0, 32'h1, "bus timeout");
      tally_and_finish();
    end
    {cyc_i, stb_i} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    wb(a, 1'b1, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe, input string s);
    logic [31:0] q;
    logic        e;
    wb(a, 1'b0, 32'h0, q, e);
    chk({31'h0, e}, {31'h0, xe}, s);
    if (!xe)
      chk(q, x, s);
  endtask

  // Main sequence
  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, led_src_i, pin_irq_enable_i} = '0;
    {rom_clk_src_i, rom_dat_src_i, rom_dat_oe_src_i, mii_dbg_i, ext_en, ext_val} = '0;
    {n_mismatch, n_checks} = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS, 32'h00000007, 1'b0, "reset value");
    chk({31'h0, rom_clock_pin_oe_o}, 32'h1, "rom clock driven");
    wr(OFS, 32'h8888F8E0);
    rd(OFS, 32'h00000007, 1'b0, "reserved bits");
    rd(8'h8C, 32'h0, 1'b1, "unmapped read");
    wr(8'h8C, 32'h00000700);
    rd(OFS, 32'h00000007, 1'b0, "unmapped write");
    $display("test reset done");
    wr(OFS, 32'h00050703);
    repeat (2) @(posedge clk_i);
    chk({29'h0, pin_oe_o}, 32'h5, "drive enables");
    chk({29'h0, pin_o & pin_oe_o}, 32'h1, "driven data");
    rd(OFS, 32'h00050703, 1'b0, "output readback");
    ext_en <= 3'h7;
    ext_val <= 3'h5;
    wr(OFS, 32'h00000002);
    rd(OFS, 32'h00000005, 1'b0, "input readback");
    led_src_i <= 3'h6;
    wr(OFS, 32'h70070000);
    repeat (2) @(posedge clk_i);
    chk({29'h0, pin_oe_o}, 32'h7, "led drive");
    chk({29'h0, pin_o}, 32'h6, "led values");
    $display("test pins done");
    ext_val <= 3'h6;
    pin_irq_enable_i <= 3'h1;
    wr(OFS, 32'h01000000);
    repeat (8) @(posedge clk_i);
    chk({29'h0, pin_irq_status_o}, 32'h0, "inactive levels");
    ext_val <= 3'h7;
    for (t = 0; t < 20 && pin_irq_o !== 1'b1; t++)
      @(posedge clk_i);
    chk({31'h0, pin_irq_o}, 32'h1, "irq raised");
    if (t == 20)
      tally_and_finish();
    chk({29'h0, pin_irq_status_o}, 32'h1, "high level sets");
    pin_irq_enable_i <= 3'h0;
    ext_val <= 3'h4;
    repeat (10) @(posedge clk_i);
    chk({31'h0, pin_irq_o}, 32'h0, "irq masked");
    chk({29'h0, pin_irq_status_o}, 32'h2, "low level sets");
    ext_val <= 3'h6;
    repeat (6) @(posedge clk_i);
    ext_val <= 3'h7;
    @(posedge clk_i);
    ext_val <= 3'h6;
    repeat (6) @(posedge clk_i);
    chk({29'h0, pin_irq_status_o}, 32'h0, "short pulse ignored");
    $display("test irq done");
    for (int c = 0; c < 6; c++)
      for (int p = 0; p < 3; p++)
      begin
        {rom_dat_src_i, rom_clk_src_i, rom_dat_oe_src_i} <= {p == 0, p == 0, p != 1};
        mii_dbg_i <= '{tx_en: p < 2, rx_dv: p < 2, tx_clk: p == 2, rx_clk: p == 2};
        // Reserved codes skipped, no rom cycle open
        wr(OFS, {9'h0, fn_tab[c], 15'h0, {2{p == 1}}, 3'h0});
        repeat (2) @(posedge clk_i);
        chk({31'h0, rom_data_pin_o}, (dsel[c] >> p) & 1, "data pin");
        chk({31'h0, rom_clock_pin_o}, (csel[c] >> p) & 1, "clock pin");
        chk({31'h0, rom_data_pin_oe_o}, (c == 0) ? (p != 1) : 1, "data oe");
        chk({31'h0, rom_clock_pin_oe_o}, 32'h1, "clock oe");
        chk({31'h0, rom_dat_in_o}, (c == 0 && p == 1) ? 1 : ((dsel[c] >> p) & 1), "data in");
      end
    $display("test rom pins done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
